// file: logic/sll_map.vh
// Purpose: Register offsets, field positions, reset values and timing
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: Definitions only
`ifndef SLL_MAP_VH
`define SLL_MAP_VH

// Register byte offsets
`define SLL_ADDR_W 8
`define SLL_OFF_CTRL 8'h00
`define SLL_OFF_STATUS 8'h04
`define SLL_OFF_SLOT_MASK 8'h08
`define SLL_OFF_INT_STAT 8'h0C
`define SLL_OFF_INT_MASK 8'h10
`define SLL_OFF_LOOP_CNT 8'h14

// Control fields
`define SLL_CTRL_MGMT_LOOP 0
`define SLL_CTRL_LAMP_TEST 1
`define SLL_CTRL_W 2
`define SLL_CTRL_RST 2'h0

// Status fields
`define SLL_ST_LOOP 0
`define SLL_ST_LINK 1
`define SLL_ST_SWITCH 2
`define SLL_ST_LEAD 3
`define SLL_ST_MGMT 4
`define SLL_ST_W 5

// Interrupt event fields
`define SLL_EV_LOOP_ON 0
`define SLL_EV_LOOP_OFF 1
`define SLL_EV_LINK_UP 2
`define SLL_EV_LINK_DOWN 3
`define SLL_EV_W 4
`define SLL_INT_RST 4'h0

// Timeslot mask reset: all timeslots active
`define SLL_SLOT_MASK_RST 32'hFFFFFFFF
`define SLL_SLOTS 32
`define SLL_BITS_PER_SLOT 8

// Timing
`define SLL_CLK_KHZ 25000
`define SLL_TICK_MS 1
`define SLL_BLINK_PERIOD_MS 500
`define SLL_BLINK_ON_MS 100

`endif

// file: logic/sll_sync.v
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Single destination clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps

module sll_sync #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;

endmodule

// file: logic/sll_top.v
// Purpose: Status LEDs and local loopback control of a line card
// Assumes: Data, strobe and link inputs are synchronous to pclk
// Notes: Switch and lead inputs are asynchronous and synchronised here
//
// Functional notes
// - Transmit LED green for a sent one, yellow for a sent zero.
// - Transmit LED lit only in active timeslots or during lamp test, dark otherwise.
// - Receive LED green for one, yellow for zero, dark when inactive unless lamp test is on.
// - Link LED green while a live line connection is detected.
// - Test mode LED blinks yellow briefly while local loopback is active.
// - In loopback, terminal transmit data is returned on terminal receive.
// - Loopback entered by management, terminal lead or panel switch.
`timescale 1ns/1ps
`include "sll_map.vh"

module sll_top #(
	parameter TICK_CYCLES = `SLL_CLK_KHZ * `SLL_TICK_MS,
	parameter TICK_W = 16,
	parameter BLINK_PERIOD_TICKS = `SLL_BLINK_PERIOD_MS / `SLL_TICK_MS,
	parameter BLINK_ON_TICKS = `SLL_BLINK_ON_MS / `SLL_TICK_MS,
	parameter BLINK_W = 10
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`SLL_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq,
	input wire bit_strobe,
	input wire frame_start,
	input wire term_txd,
	output reg term_rxd,
	output reg line_txd,
	input wire line_rxd,
	input wire line_signal_detect,
	input wire loopback_panel_switch,
	input wire terminal_loopback_request,
	output reg tx_led_green,
	output reg tx_led_yellow,
	output reg rx_led_green,
	output reg rx_led_yellow,
	output reg link_led_green,
	output reg test_mode_led,
	output reg loopback_active
);

	// Counts cut to counter width on purpose
	localparam integer TICK_LAST_I = TICK_CYCLES - 1;
	localparam integer BLINK_LAST_I = BLINK_PERIOD_TICKS - 1;
	localparam integer BLINK_ON_I = BLINK_ON_TICKS;
	localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_I[TICK_W-1:0];
	localparam [BLINK_W-1:0] BLINK_LAST = BLINK_LAST_I[BLINK_W-1:0];
	localparam [BLINK_W-1:0] BLINK_ON = BLINK_ON_I[BLINK_W-1:0];

	// Register state
	reg [`SLL_CTRL_W-1:0] ctrl_reg;
	reg [31:0] slot_mask_reg;
	reg [`SLL_EV_W-1:0] int_stat_reg;
	reg [`SLL_EV_W-1:0] int_stat_next;
	reg [`SLL_EV_W-1:0] int_mask_reg;
	reg [7:0] loop_cnt_reg;

	// Frame position
	reg [7:0] bit_cnt_reg;
	wire [7:0] cur_bit;
	wire [4:0] cur_slot;
	wire slot_on;

	// Loopback request merge
	wire switch_sync;
	wire lead_sync;
	wire mgmt_req;
	wire loop_req;
	reg link_reg;

	// Blink timing
	reg [TICK_W-1:0] tick_cnt_reg;
	reg tick_reg;
	reg [BLINK_W-1:0] blink_cnt_reg;

	// APB decode
	wire setup_ph;
	wire access_ph;
	wire wr_en;
	wire rd_en;
	reg addr_hit;
	reg [31:0] rd_data;
	wire [`SLL_EV_W-1:0] events;
	wire [`SLL_EV_W-1:0] rd_clear;
	wire lamp_test;

	sll_sync #(
		.WIDTH(1)
	) u_switch_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din(loopback_panel_switch),
		.dout(switch_sync)
	);

	sll_sync #(
		.WIDTH(1)
	) u_lead_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din(terminal_loopback_request),
		.dout(lead_sync)
	);

	assign mgmt_req = ctrl_reg[`SLL_CTRL_MGMT_LOOP];
	assign lamp_test = ctrl_reg[`SLL_CTRL_LAMP_TEST];
	assign loop_req = mgmt_req | switch_sync | lead_sync;

	// Loopback state and link detect
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loopback_active <= 1'b0;
			link_reg <= 1'b0;
			loop_cnt_reg <= 8'h00;
		end else begin
			loopback_active <= loop_req;
			link_reg <= line_signal_detect;
			if (loop_req && !loopback_active) begin
				loop_cnt_reg <= loop_cnt_reg + 8'h01;
			end
		end
	end

	assign events[`SLL_EV_LOOP_ON] = loop_req & ~loopback_active;
	assign events[`SLL_EV_LOOP_OFF] = ~loop_req & loopback_active;
	assign events[`SLL_EV_LINK_UP] = line_signal_detect & ~link_reg;
	assign events[`SLL_EV_LINK_DOWN] = ~line_signal_detect & link_reg;

	// Frame bit position and timeslot
	assign cur_bit = frame_start ? 8'h00 : bit_cnt_reg;
	assign cur_slot = cur_bit[7:3];
	assign slot_on = slot_mask_reg[cur_slot];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_reg <= 8'h00;
		end else if (bit_strobe) begin
			bit_cnt_reg <= cur_bit + 8'h01;
		end
	end

	// Data path and activity LEDs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_txd <= 1'b1;
			term_rxd <= 1'b1;
			tx_led_green <= 1'b0;
			tx_led_yellow <= 1'b0;
			rx_led_green <= 1'b0;
			rx_led_yellow <= 1'b0;
		end else if (lamp_test) begin
			tx_led_green <= 1'b1;
			tx_led_yellow <= 1'b0;
			rx_led_green <= 1'b1;
			rx_led_yellow <= 1'b0;
			if (bit_strobe) begin
				line_txd <= term_txd;
				term_rxd <= loop_req ? term_txd : line_rxd;
			end
		end else if (bit_strobe) begin
			line_txd <= term_txd;
			term_rxd <= loop_req ? term_txd : line_rxd;
			tx_led_green <= slot_on & term_txd;
			tx_led_yellow <= slot_on & ~term_txd;
			rx_led_green <= slot_on & line_rxd;
			rx_led_yellow <= slot_on & ~line_rxd;
		end
	end

	// Link LED
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_led_green <= 1'b0;
		end else begin
			link_led_green <= line_signal_detect | lamp_test;
		end
	end

	// Millisecond tick divider
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= {TICK_W{1'b0}};
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == TICK_LAST) begin
			tick_cnt_reg <= {TICK_W{1'b0}};
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + {{(TICK_W-1){1'b0}}, 1'b1};
			tick_reg <= 1'b0;
		end
	end

	// Test mode blink: brief flash each period during loopback
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_reg <= {BLINK_W{1'b0}};
			test_mode_led <= 1'b0;
		end else if (!loopback_active) begin
			blink_cnt_reg <= {BLINK_W{1'b0}};
			test_mode_led <= lamp_test;
		end else begin
			if (tick_reg) begin
				if (blink_cnt_reg == BLINK_LAST) begin
					blink_cnt_reg <= {BLINK_W{1'b0}};
				end else begin
					blink_cnt_reg <= blink_cnt_reg
						+ {{(BLINK_W-1){1'b0}}, 1'b1};
				end
			end
			test_mode_led <= (blink_cnt_reg < BLINK_ON) | lamp_test;
		end
	end

	// APB phases
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable & pready;
	assign wr_en = access_ph & pwrite & ~pslverr;
	assign rd_en = access_ph & ~pwrite & ~pslverr;

	// Read mux, evaluated in the setup phase
	always @* begin
		addr_hit = 1'b1;
		rd_data = 32'h00000000;
		case (paddr)
			`SLL_OFF_CTRL: begin
				rd_data[`SLL_CTRL_W-1:0] = ctrl_reg;
			end
			`SLL_OFF_STATUS: begin
				rd_data[`SLL_ST_LOOP] = loopback_active;
				rd_data[`SLL_ST_LINK] = link_reg;
				rd_data[`SLL_ST_SWITCH] = switch_sync;
				rd_data[`SLL_ST_LEAD] = lead_sync;
				rd_data[`SLL_ST_MGMT] = mgmt_req;
			end
			`SLL_OFF_SLOT_MASK: begin
				rd_data = slot_mask_reg;
			end
			`SLL_OFF_INT_STAT: begin
				rd_data[`SLL_EV_W-1:0] = int_stat_reg;
			end
			`SLL_OFF_INT_MASK: begin
				rd_data[`SLL_EV_W-1:0] = int_mask_reg;
			end
			`SLL_OFF_LOOP_CNT: begin
				rd_data[7:0] = loop_cnt_reg;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// Zero-wait slave: answer in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setup_ph) begin
			pready <= 1'b1;
			pslverr <= ~addr_hit;
			prdata <= (pwrite || !addr_hit) ? 32'h00000000 : rd_data;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Writable registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `SLL_CTRL_RST;
			slot_mask_reg <= `SLL_SLOT_MASK_RST;
			int_mask_reg <= `SLL_INT_RST;
		end else if (wr_en) begin
			case (paddr)
				`SLL_OFF_CTRL: begin
					ctrl_reg <= pwdata[`SLL_CTRL_W-1:0];
				end
				`SLL_OFF_SLOT_MASK: begin
					slot_mask_reg <= pwdata;
				end
				`SLL_OFF_INT_MASK: begin
					int_mask_reg <= pwdata[`SLL_EV_W-1:0];
				end
				default: begin
					ctrl_reg <= ctrl_reg;
				end
			endcase
		end
	end

	// Sticky events, cleared by reading; a new event wins over the clear
	assign rd_clear = (rd_en && paddr == `SLL_OFF_INT_STAT)
		? {`SLL_EV_W{1'b1}} : {`SLL_EV_W{1'b0}};

	always @* begin
		int_stat_next = (int_stat_reg & ~rd_clear) | events;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_reg <= `SLL_INT_RST;
			irq <= 1'b0;
		end else begin
			int_stat_reg <= int_stat_next;
			irq <= |(int_stat_next & int_mask_reg);
		end
	end

endmodule

// file: verification/sll_chk.sv
// Purpose: Port checks of sll_top
// Assumes: One clock, async low reset
// Notes: Bound after the module
`timescale 1ns/1ps
module sll_chk (
	input wire pclk,
	input wire presetn,
	input wire bit_strobe,
	input wire term_txd,
	input wire line_rxd,
	input wire line_signal_detect,
	input wire loopback_panel_switch,
	input wire terminal_loopback_request,
	input wire term_rxd,
	input wire line_txd,
	input wire tx_led_yellow,
	input wire link_led_green,
	input wire test_mode_led,
	input wire loopback_active
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_lp;
		bit_strobe ##1 loopback_active;
	endsequence
	sequence s_np;
		bit_strobe ##1 !loopback_active;
	endsequence
	sequence s_rq;
		(terminal_loopback_request || loopback_panel_switch) [*3];
	endsequence
	a_tx_one:
	assert property (bit_strobe && term_txd |=> !tx_led_yellow)
		else $error("tx one");
	a_line_tx:
	assert property (bit_strobe |=> line_txd == $past(term_txd))
		else $error("line tx");
	a_link_on:
	assert property (line_signal_detect |=> link_led_green)
		else $error("link");
	a_tm_entry:
	assert property ($rose(loopback_active) |=> test_mode_led)
		else $error("tm");
	a_loop_echo:
	assert property (s_lp |-> term_rxd == $past(term_txd))
		else $error("echo");
	a_thru_rx:
	assert property (s_np |-> term_rxd == $past(line_rxd))
		else $error("thru");
	a_loop_req:
	assert property (s_rq |=> loopback_active)
		else $error("req");
	a_loop_end:
	assert property ($fell(loopback_active) |->
		!$past(terminal_loopback_request, 3) &&
		!$past(loopback_panel_switch, 3))
		else $error("end");
endmodule
bind sll_top sll_chk u_chk (.*);

// file: verification/sll_dte.sv
// Purpose: Terminal model on the serial port
// Assumes: Data moves on after each bit strobe
// Notes: Fixed rotating pattern
`timescale 1ns/1ps
module sll_dte (
	input wire pclk,
	input wire bit_strobe,
	input wire lead_cmd,
	output wire term_txd,
	output reg terminal_loopback_request = 1'b0
);
	reg [7:0] pat_reg = 8'hB4;
	assign term_txd = pat_reg[7];
	always @(posedge pclk) begin
		if (bit_strobe) begin
			pat_reg <= {pat_reg[6:0], pat_reg[7]};
		end
		terminal_loopback_request <= lead_cmd;
	end
endmodule

// file: verification/tb_top.sv
// Purpose: Self-checking bench of sll_top
// Assumes: Short tick and blink counts
// Notes: Terminal is sll_dte
`timescale 1ns/1ps
`include "sll_map.vh"
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic bit_strobe = 0, frame_start = 0, line_rxd = 0;
	logic line_signal_detect = 0, loopback_panel_switch = 0;
	logic lead_cmd = 0, b, serr;
	logic [1:0] e;
	wire [31:0] prdata;
	wire pready, pslverr, irq, term_txd, term_rxd, line_txd;
	wire tx_led_green, tx_led_yellow, rx_led_green, rx_led_yellow;
	wire link_led_green, test_mode_led, loopback_active;
	wire terminal_loopback_request;
	integer err_count = 0, checks = 0;
	sll_top #(.TICK_CYCLES(4), .BLINK_PERIOD_TICKS(10),
		.BLINK_ON_TICKS(3)) uut (.*);
	sll_dte u_dte (.*);
	always #20 pclk = ~pclk;
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		begin
			checks = checks + 1;
			if (s !== x) begin
				err_count = err_count + 1;
				$display("unexpected %s exp %h seen %h", nm, x, s);
			end
		end
	endtask
	task finish_test;
		begin
			$display("errors %0d checks %0d", err_count, checks);
			if (err_count == 0 && checks > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		begin
			@(posedge pclk);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			n = 0;
			do begin
				@(posedge pclk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 9);
			rd = prdata;
			serr = pslverr;
			psel <= 0;
			penable <= 0;
			if (pready !== 1'b1) begin
				err_count = err_count + 1;
				finish_test;
			end
		end
	endtask
	task strb(input logic fs, input logic rx);
		begin
			@(posedge pclk);
			bit_strobe <= 1;
			frame_start <= fs;
			line_rxd <= rx;
			@(posedge pclk);
			b = term_txd;
			bit_strobe <= 0;
			#1;
		end
	endtask
	task wait_loop(input logic v);
		integer n;
		begin
			n = 0;
			while (loopback_active !== v && n < 10) begin
				@(posedge pclk);
				#1;
				n = n + 1;
			end
			chk("loopback_active", loopback_active, v);
			if (loopback_active !== v) begin
				finish_test;
			end
		end
	endtask
	task set_src(input integer s, input logic v);
		begin
			@(posedge pclk);
			case (s)
				0: apb(1, `SLL_OFF_CTRL, {31'h0, v});
				1: lead_cmd <= v;
				default: loopback_panel_switch <= v;
			endcase
		end
	endtask
	task t_data;
		integer i;
		begin
			apb(0, `SLL_OFF_SLOT_MASK, 32'h0);
			chk("slot_mask", rd, `SLL_SLOT_MASK_RST);
			for (i = 0; i < 2; i = i + 1) begin
				strb(i == 0, i[0]);
				chk("tx", {tx_led_green, tx_led_yellow}, {b, !b});
				chk("rx", {rx_led_green, rx_led_yellow}, {i[0], !i[0]});
				chk("data", {line_txd, term_rxd}, {b, i[0]});
			end
		end
	endtask
	task t_slot;
		integer i;
		begin
			apb(1, `SLL_OFF_SLOT_MASK, 32'hFFFFFFFE);
			for (i = 0; i < 9; i = i + 1) begin
				strb(i == 0, 1'b1);
				e = (i < 8) ? 2'h0 : {b, !b};
				chk("tx", {tx_led_green, tx_led_yellow}, e);
				e = (i < 8) ? 2'h0 : 2'h2;
				chk("rx", {rx_led_green, rx_led_yellow}, e);
			end
		end
	endtask
	task t_link;
		begin
			@(posedge pclk);
			line_signal_detect <= 1;
			repeat (3) @(posedge pclk);
			#1;
			chk("link", link_led_green, 1);
			chk("irq", irq, 0);
			apb(1, `SLL_OFF_INT_MASK, 32'h4);
			repeat (2) @(posedge pclk);
			#1;
			chk("irq", irq, 1);
			apb(0, `SLL_OFF_INT_STAT, 32'h0);
			chk("int_stat", rd, 32'h4);
			repeat (2) @(posedge pclk);
			#1;
			chk("irq", irq, 0);
			@(posedge pclk);
			line_signal_detect <= 0;
			repeat (3) @(posedge pclk);
			#1;
			chk("link", link_led_green, 0);
		end
	endtask
	task t_loop;
		integer s;
		begin
			for (s = 0; s < 3; s = s + 1) begin
				set_src(s, 1);
				wait_loop(1);
				@(posedge pclk);
				#1;
				chk("tm", test_mode_led, 1);
				repeat (30) @(posedge pclk);
				#1;
				chk("tm", test_mode_led, 0);
				strb(0, !term_txd);
				chk("echo", term_rxd, b);
				set_src(s, 0);
				wait_loop(0);
			end
		end
	endtask
	task t_both;
		begin
			set_src(1, 1);
			set_src(2, 1);
			wait_loop(1);
			apb(0, `SLL_OFF_STATUS, 32'h0);
			chk("status", rd, 32'hD);
			set_src(2, 0);
			repeat (6) @(posedge pclk);
			#1;
			chk("loopback_active", loopback_active, 1);
			set_src(1, 0);
			wait_loop(0);
			apb(0, `SLL_OFF_LOOP_CNT, 32'h0);
			chk("loop_cnt", rd, 32'h4);
			apb(0, `SLL_OFF_INT_STAT, 32'h0);
			chk("int_stat", rd, 32'hB);
			apb(0, 8'h18, 32'h0);
			chk("pslverr", serr, 1);
		end
	endtask
	task t_lamp;
		begin
			apb(1, `SLL_OFF_CTRL, 32'h2);
			@(posedge pclk);
			#1;
			chk("lamp_link", link_led_green, 1);
			chk("lamp_tm", test_mode_led, 1);
			chk("lamp_tx", tx_led_green, 1);
			chk("lamp_loop", loopback_active, 0);
			apb(1, `SLL_OFF_CTRL, 32'h0);
			@(posedge pclk);
			#1;
			chk("lamp_off", {link_led_green, test_mode_led}, 0);
		end
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_data;
		t_slot;
		t_link;
		t_loop;
		t_both;
		t_lamp;
		finish_test;
	end
endmodule
